/* File: rtl/mdt_decode.sv */
// instruction decoder with instruction-cycle timing and apb registers
// assumes apb master on ref_clk; software loads instruction words and
// reports condition outcomes, the block decodes fields and times cycles
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module mdt_decode (
    input  wire logic                  ref_clk,     // core clock, 10 MHz
    input  wire logic                  rst_n,       // async reset, active low
    input  wire logic                  psel,        // apb select
    input  wire logic                  penable,     // apb enable
    input  wire logic                  pwrite,      // apb write
    input  wire logic [11:0]           paddr,       // apb byte address
    input  wire logic [31:0]           pwdata,      // apb write data
    output logic                       pready,      // apb ready
    output logic [31:0]                prdata,      // apb read data
    output logic                       pslverr,     // apb error, unmapped
    output mdt_pkg::mdt_fmt_t          fmt,         // decoded format
    output logic                       dest_is_file, // result goes to file reg
    output logic                       wr_accum,    // result goes to accumulator
    output logic [11:0]                data_addr,   // full data address
    output logic                       shadow_upd,  // fast call/return
    output logic                       cyc_strobe,  // end of instruction cycle
    output logic                       instr_done   // instruction finished
);
    import mdt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // functions
    function automatic logic is_second(input logic [15:0] w);
        return w[15:12] == MDT_SECOND_NIB;
    endfunction

    function automatic logic [11:0] byte_addr(input logic [15:0] w, input logic [3:0] bank);
        if (w[8]) begin
            return {bank, w[7:0]};
        end else begin
            return {4'h0, w[7:0]};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] instr_r;
    logic [15:0] word2_r;
    logic [3:0]  bank_r;
    logic [20:0] prog_table_pointer_r;
    logic [7:0]  tlat_r;
    logic [4:0]  flags_r;
    logic        taken_r;
    logic        pcchg_r;
    logic        wr_en;
    logic        rd_en;
    logic        start;
    mdt_state_t  state_r;
    logic [1:0]  phase_r;
    logic [1:0]  cyc_cnt_r;
    logic [1:0]  cyc_need;
    logic [1:0]  tmode;

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(paddr == MDT_OFS_INSTR || paddr == MDT_OFS_CTRL ||
                     paddr == MDT_OFS_FIELD || paddr == MDT_OFS_ADDR || paddr == MDT_OFS_TIMING ||
                     paddr == MDT_OFS_TABLE || paddr == MDT_OFS_STATUS);
    assign start   = wr_en & (paddr == MDT_OFS_CTRL) & pwdata[MDT_CTRL_START];

    ////////////////////////////////////////////////////////////////////////
    // software-written state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_r <= MDT_RST_INSTR;
            word2_r <= MDT_RST_INSTR;
            bank_r  <= MDT_RST_BANK;
            taken_r <= 1'b0;
            pcchg_r <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                MDT_OFS_INSTR: begin
                    instr_r <= pwdata[15:0];
                    word2_r <= pwdata[31:16];
                end
                MDT_OFS_CTRL: begin
                    taken_r <= pwdata[MDT_CTRL_TAKEN];
                    pcchg_r <= pwdata[MDT_CTRL_PCCHG];
                    bank_r  <= pwdata[11:8];
                end
                default: ;
            endcase
        end
    end

    // flags: software supplies alu outcomes for this instruction
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= MDT_RST_FLAGS;
        end else if (wr_en && paddr == MDT_OFS_STATUS) begin
            flags_r <= pwdata[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // format decode
    always_comb begin
        fmt = MDT_FMT_OTHER;
        if (is_second(instr_r)) begin
            fmt = MDT_FMT_SECOND;
        end else if (instr_r[15:12] == 4'hc) begin
            fmt = MDT_FMT_MOVE2;
        end else if (instr_r[15:8] == 8'hee && instr_r[7:6] == 2'b00) begin
            fmt = MDT_FMT_PTRLD;
        end else if (instr_r[15:9] == 7'b1110110 || instr_r[15:8] == 8'hef) begin
            fmt = MDT_FMT_CALLGO;
        end else if (instr_r[15:11] == 5'b11010 || instr_r[15:11] == 5'b11100) begin
            fmt = MDT_FMT_BRREL;
        end else if (instr_r[15:4] == 12'h000 && instr_r[3]) begin
            fmt = MDT_FMT_TABLE;
        end else if (instr_r[15:1] == 15'h0009) begin
            fmt = MDT_FMT_RET;
        end else if (instr_r[15:12] == 4'h0 && instr_r[11:8] >= 4'h8) begin
            fmt = MDT_FMT_LIT;
        end else if (instr_r[15:12] >= 4'h7 && instr_r[15:12] <= 4'hb) begin
            fmt = MDT_FMT_BIT;
        end else if (instr_r[15:9] == 7'b0110000 || instr_r[15:9] == 7'b0110001 ||
                     instr_r[15:9] == 7'b0110010 || instr_r[15:9] == 7'b0110011 ||
                     instr_r[15:10] == 6'b001011 || instr_r[15:10] == 6'b001111 ||
                     instr_r[15:11] == 5'b01001) begin
            fmt = MDT_FMT_SKIP;
        end else if (instr_r[15:12] <= 4'h6 && instr_r[15:8] != 8'h00) begin
            fmt = MDT_FMT_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand fields
    logic [2:0]  bit_num;
    logic [7:0]  lit8;
    logic [11:0] lit12;
    logic [19:0] lit20;
    logic [1:0]  ptr_sel;
    logic [11:0] src12;
    logic [11:0] dst12;
    logic [20:0] br_off;
    logic [6:0]  zs_off;
    logic [6:0]  zd_off;

    assign bit_num = instr_r[11:9];
    assign lit8    = instr_r[7:0];
    assign lit12   = {instr_r[3:0], word2_r[7:0]};
    assign lit20   = {word2_r[11:0], instr_r[7:0]};
    assign ptr_sel = instr_r[5:4];
    assign src12   = instr_r[11:0];
    assign dst12   = word2_r[11:0];
    assign zs_off  = instr_r[6:0];
    assign zd_off  = word2_r[6:0];
    assign tmode   = instr_r[1:0];

    // signed offset: 11 bits for bra/rcall, 8 bits for conditional
    always_comb begin
        if (instr_r[15:12] == 4'hd) begin
            br_off = {{10{instr_r[10]}}, instr_r[10:0]};
        end else begin
            br_off = {{13{instr_r[7]}}, instr_r[7:0]};
        end
    end

    always_comb begin
        dest_is_file = (fmt == MDT_FMT_BYTE) & instr_r[9];
        wr_accum     = (fmt == MDT_FMT_BYTE) & ~instr_r[9];
        // call carries its fast bit at bit 8, return at bit 0
        shadow_upd   = ((fmt == MDT_FMT_CALLGO) & instr_r[8] & (instr_r[15:8] != 8'hef)) |
                       ((fmt == MDT_FMT_RET) & instr_r[0]);
        if (fmt == MDT_FMT_MOVE2) begin
            data_addr = src12;
        end else begin
            data_addr = byte_addr(instr_r, bank_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction cycle timing
    always_comb begin
        case (fmt)
            MDT_FMT_MOVE2, MDT_FMT_PTRLD, MDT_FMT_CALLGO: cyc_need = 2'd2;
            MDT_FMT_SKIP: begin
                if (taken_r) begin
                    cyc_need = is_second(word2_r) ? 2'd3 : 2'd2;
                end else begin
                    cyc_need = 2'd1;
                end
            end
            MDT_FMT_TABLE, MDT_FMT_RET: cyc_need = 2'd2;
            MDT_FMT_SECOND: cyc_need = 2'd1;
            default: cyc_need = (taken_r | pcchg_r) ? 2'd2 : 2'd1;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= MDT_ST_IDLE;
            phase_r   <= 2'd0;
            cyc_cnt_r <= 2'd0;
        end else begin
            case (state_r)
                MDT_ST_IDLE: begin
                    if (start) begin
                        state_r   <= MDT_ST_EXEC;
                        phase_r   <= 2'd0;
                        cyc_cnt_r <= 2'd0;
                    end
                end
                MDT_ST_EXEC: begin
                    phase_r <= phase_r + 2'd1;
                    if (phase_r == MDT_PHASE_LAST) begin
                        cyc_cnt_r <= cyc_cnt_r + 2'd1;
                        if (cyc_cnt_r + 2'd1 == cyc_need) begin
                            state_r <= MDT_ST_DONE;
                        end
                    end
                end
                MDT_ST_DONE: state_r <= MDT_ST_IDLE;
                default: state_r <= MDT_ST_IDLE;
            endcase
        end
    end

    assign cyc_strobe = (state_r == MDT_ST_EXEC) & (phase_r == MDT_PHASE_LAST);
    assign instr_done = (state_r == MDT_ST_DONE);

    ////////////////////////////////////////////////////////////////////////
    // table pointer and latch
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prog_table_pointer_r <= MDT_RST_TBLP;
            tlat_r   <= MDT_RST_TLAT;
        end else if (wr_en && paddr == MDT_OFS_TABLE) begin
            prog_table_pointer_r <= pwdata[20:0];
            tlat_r   <= pwdata[31:24];
        end else if (instr_done && fmt == MDT_FMT_TABLE) begin
            case (tmode)
                MDT_TM_POSTINC, MDT_TM_PREINC: prog_table_pointer_r <= prog_table_pointer_r + 21'd1;
                MDT_TM_POSTDEC: prog_table_pointer_r <= prog_table_pointer_r - 21'd1;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                MDT_OFS_INSTR:  prdata <= {word2_r, instr_r};
                MDT_OFS_CTRL:   prdata <= {20'h00000, bank_r, 5'h00, pcchg_r, 1'b0, taken_r};
                MDT_OFS_FIELD:  prdata <= {fmt, zd_off, zs_off, ptr_sel, bit_num, lit8, dest_is_file};
                MDT_OFS_ADDR:   prdata <= {data_addr, lit20};
                MDT_OFS_TIMING: prdata <= {11'h000, br_off};
                MDT_OFS_TABLE:  prdata <= {tlat_r, 3'h0, prog_table_pointer_r};
                MDT_OFS_STATUS: prdata <= {10'h000, dst12, shadow_upd, cyc_need, state_r, flags_r};
                default:        prdata <= 32'h00000000;
            endcase
        end
    end

    logic unused_ok;
    assign unused_ok = rd_en & (|lit12);
endmodule

/* File: rtl/mdt_pkg.sv */
// package for the instruction decode and timing block
// assumes a single core clock and a 32-bit apb register bus
package mdt_pkg;
    // register byte addresses
    localparam logic [11:0] MDT_OFS_INSTR  = 12'h000;
    localparam logic [11:0] MDT_OFS_CTRL   = 12'h004;
    localparam logic [11:0] MDT_OFS_FIELD  = 12'h008;
    localparam logic [11:0] MDT_OFS_ADDR   = 12'h00c;
    localparam logic [11:0] MDT_OFS_TIMING = 12'h010;
    localparam logic [11:0] MDT_OFS_TABLE  = 12'h014;
    localparam logic [11:0] MDT_OFS_STATUS = 12'h018;
    // reset values
    localparam logic [15:0] MDT_RST_INSTR = 16'h0000;
    localparam logic [3:0]  MDT_RST_BANK  = 4'h0;
    localparam logic [20:0] MDT_RST_TBLP  = 21'h000000;
    localparam logic [7:0]  MDT_RST_TLAT  = 8'h00;
    localparam logic [4:0]  MDT_RST_FLAGS = 5'h00;
    // timing: one instruction cycle is four oscillator periods
    localparam int          MDT_OSC_PER_CYC = 4;
    localparam logic [1:0]  MDT_PHASE_LAST  = 2'(MDT_OSC_PER_CYC - 1);
    // second-word marker in the top nibble
    localparam logic [3:0]  MDT_SECOND_NIB = 4'hf;
    // ctrl field positions
    localparam int MDT_CTRL_TAKEN  = 0;
    localparam int MDT_CTRL_START  = 1;
    localparam int MDT_CTRL_PCCHG  = 2;
    // flag positions
    localparam int MDT_FLG_C  = 0;
    localparam int MDT_FLG_DC = 1;
    localparam int MDT_FLG_Z  = 2;
    localparam int MDT_FLG_OV = 3;
    localparam int MDT_FLG_N  = 4;

    typedef enum logic [3:0] {
        MDT_FMT_BYTE   = 4'b0000,
        MDT_FMT_BIT    = 4'b0001,
        MDT_FMT_LIT    = 4'b0010,
        MDT_FMT_MOVE2  = 4'b0011,
        MDT_FMT_PTRLD  = 4'b0100,
        MDT_FMT_CALLGO = 4'b0101,
        MDT_FMT_BRREL  = 4'b0110,
        MDT_FMT_TABLE  = 4'b0111,
        MDT_FMT_RET    = 4'b1000,
        MDT_FMT_SECOND = 4'b1001,
        MDT_FMT_SKIP   = 4'b1010,
        MDT_FMT_OTHER  = 4'b1011
    } mdt_fmt_t;

    typedef enum logic [1:0] {
        MDT_TM_NONE = 2'b00,
        MDT_TM_POSTINC = 2'b01,
        MDT_TM_POSTDEC = 2'b10,
        MDT_TM_PREINC  = 2'b11
    } mdt_tmode_t;

    typedef enum logic [1:0] {
        MDT_ST_IDLE  = 2'b00,
        MDT_ST_EXEC  = 2'b01,
        MDT_ST_DONE  = 2'b10
    } mdt_state_t;
endpackage

/* File: test/mdt_decode_asserts.sv */
// port checker for the instruction decode block
// assumes mdt_pkg and the top ports of mdt_decode
`timescale 1ns/10ps
module mdt_chk (
    input wire logic              ref_clk,      // core clock
    input wire logic              rst_n,        // async reset
    input wire logic              psel,         // apb select
    input wire logic              penable,      // apb enable
    input wire logic              pwrite,       // apb write
    input wire logic [11:0]       paddr,        // apb address
    input wire logic [31:0]       pwdata,       // apb write data
    input wire logic              pready,       // apb ready
    input wire logic              pslverr,      // apb error
    input wire mdt_pkg::mdt_fmt_t fmt,          // decoded format
    input wire logic              dest_is_file, // result to file reg
    input wire logic              wr_accum,     // result to accumulator
    input wire logic              shadow_upd,   // fast call/return
    input wire logic              cyc_strobe,   // cycle end
    input wire logic              instr_done    // instruction end
);
    import mdt_pkg::*;
    logic start;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // start pulse written to the control register
    assign start = psel && penable && pwrite && paddr == MDT_OFS_CTRL && pwdata[MDT_CTRL_START];
    ////////////////////////////////////////////////////////////////////////
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err; pslverr |-> psel && penable; endproperty
    a_err: assert property (p_err) else $error("pslverr outside access");
    property p_dest; dest_is_file |-> fmt == MDT_FMT_BYTE && !wr_accum; endproperty
    a_dest: assert property (p_dest) else $error("file dest wrong");
    property p_accum; wr_accum |-> fmt == MDT_FMT_BYTE; endproperty
    a_accum: assert property (p_accum) else $error("accum dest wrong");
    property p_byte; fmt == MDT_FMT_BYTE |-> dest_is_file != wr_accum; endproperty
    a_byte: assert property (p_byte) else $error("byte form lacks dest");
    property p_shadow; shadow_upd |-> fmt inside {MDT_FMT_CALLGO, MDT_FMT_RET}; endproperty
    a_shadow: assert property (p_shadow) else $error("shadow on wrong form");
    property p_gap; cyc_strobe |=> !cyc_strobe [*3]; endproperty
    a_gap: assert property (p_gap) else $error("strobe gap short");
    property p_first; start |=> !cyc_strobe [*2] ##[1:3] cyc_strobe; endproperty
    a_first: assert property (p_first) else $error("first strobe late");
    property p_done; instr_done |-> $past(cyc_strobe) && !cyc_strobe; endproperty
    a_done: assert property (p_done) else $error("done not after strobe");
    property p_pulse; instr_done |=> !instr_done; endproperty
    a_pulse: assert property (p_pulse) else $error("done too long");
    property p_bound; start |-> ##[4:14] instr_done; endproperty
    a_bound: assert property (p_bound) else $error("no done in time");
endmodule
bind mdt_decode mdt_chk mdt_chk_inst (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .fmt, .dest_is_file, .wr_accum, .shadow_upd, .cyc_strobe, .instr_done
);

/* File: test/tb.sv */
// self-checking bench for the instruction decode block
// assumes mdt_pkg, mdt_decode and its bound checker
`timescale 1ns/10ps
module tb;
    import mdt_pkg::*;
    logic        ref_clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    mdt_fmt_t    fmt;
    logic        dest_is_file;
    logic        wr_accum;
    logic [11:0] data_addr;
    logic        shadow_upd;
    logic        cyc_strobe;
    logic        instr_done;
    logic [31:0] rd;
    logic        err;
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #50 ref_clk = ~ref_clk;

    mdt_decode mdt_decode_inst (
        .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .fmt, .dest_is_file, .wr_accum, .data_addr, .shadow_upd, .cyc_strobe, .instr_done
    );

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failures++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (failures == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // let the write settle before outputs are compared
        @(negedge ref_clk);
    endtask

    // load, start, count strobes up to the done pulse
    task automatic run(input logic [31:0] ins, input logic [31:0] ctl, input int n);
        int s;
        int k;
        s = 0;
        k = 0;
        apb(1'h1, MDT_OFS_INSTR, ins);
        apb(1'h1, MDT_OFS_CTRL, ctl | 32'h2);
        while (instr_done !== 1'h1 && k < 20) begin
            @(posedge ref_clk);
            k++;
            if (cyc_strobe === 1'h1) s++;
        end
        check(32'(s), 32'(n));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(1'h0, MDT_OFS_INSTR, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, MDT_OFS_STATUS, 32'h0);
        check(rd & 32'h1f, 32'h0);
        apb(1'h1, 12'h020, 32'hffffffff);
        check(32'(err), 32'h1);
        apb(1'h0, 12'h020, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
    endtask

    task automatic t_byte();
        apb(1'h1, MDT_OFS_CTRL, 32'h500);
        apb(1'h1, MDT_OFS_INSTR, 32'h2612);
        check(32'({fmt, dest_is_file, wr_accum, data_addr}), 32'h02012);
        apb(1'h1, MDT_OFS_INSTR, 32'h25ab);
        check(32'({fmt, dest_is_file, wr_accum, data_addr}), 32'h015ab);
        apb(1'h1, MDT_OFS_INSTR, 32'h8f34);
        check(32'({fmt, data_addr}), 32'h1534);
        apb(1'h0, MDT_OFS_FIELD, 32'h0);
        check(rd & 32'he00, 32'he00);
    endtask

    task automatic t_fields();
        apb(1'h1, MDT_OFS_INSTR, 32'habccfff);
        check(32'({fmt, data_addr}), 32'h3fff);
        apb(1'h0, MDT_OFS_STATUS, 32'h0);
        check(rd & 32'h3ffc00, 32'h2af000);
        apb(1'h1, MDT_OFS_INSTR, 32'h0e7f);
        apb(1'h0, MDT_OFS_FIELD, 32'h0);
        check(rd & 32'h1fe, 32'hfe);
        apb(1'h1, MDT_OFS_INSTR, 32'hf567ee25);
        apb(1'h0, MDT_OFS_FIELD, 32'h0);
        check(rd & 32'h3000, 32'h2000);
        apb(1'h1, MDT_OFS_INSTR, 32'hf567ed34);
        check(32'(shadow_upd), 32'h1);
        apb(1'h0, MDT_OFS_ADDR, 32'h0);
        check(rd & 32'hfffff, 32'h56734);
        apb(1'h1, MDT_OFS_INSTR, 32'hf567ec34);
        check(32'(shadow_upd), 32'h0);
        apb(1'h1, MDT_OFS_INSTR, 32'hd7ff);
        apb(1'h0, MDT_OFS_TIMING, 32'h0);
        check(rd & 32'h1fffff, 32'h1fffff);
    endtask

    task automatic t_timing();
        run(32'h2612, 32'h0, 1);
        run(32'h6212, 32'h1, 2);
        run(32'h2612, 32'h4, 2);
        run(32'hf345c123, 32'h0, 2);
        run(32'hf000, 32'h0, 1);
        run(32'hf0006212, 32'h1, 3);
    endtask

    task automatic t_table();
        logic [20:0] ex [4] = '{21'h5, 21'h6, 21'h4, 21'h6};
        apb(1'h1, MDT_OFS_TABLE, 32'ha5000000);
        apb(1'h0, MDT_OFS_TABLE, 32'h0);
        check(rd & 32'hff1fffff, 32'ha5000000);
        for (int m = 0; m < 8; m++) begin
            apb(1'h1, MDT_OFS_TABLE, 32'h5);
            run(32'h8 + 32'(m), 32'h0, 2);
            apb(1'h0, MDT_OFS_TABLE, 32'h0);
            check(rd & 32'h1fffff, 32'(ex[m % 4]));
        end
        apb(1'h1, MDT_OFS_TABLE, 32'h0);
        run(32'ha, 32'h0, 2);
        apb(1'h0, MDT_OFS_TABLE, 32'h0);
        check(rd & 32'h1fffff, 32'h1fffff);
    endtask

    task automatic t_flags();
        apb(1'h1, MDT_OFS_STATUS, 32'h1f);
        apb(1'h0, MDT_OFS_STATUS, 32'h0);
        check(rd & 32'h1f, 32'h1f);
        apb(1'h1, MDT_OFS_STATUS, 32'hea);
        apb(1'h0, MDT_OFS_STATUS, 32'h0);
        check(rd & 32'h1f, 32'h0a);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'h1;
        t_reset();
        t_byte();
        t_fields();
        t_timing();
        t_table();
        t_flags();
        print_verdict();
    end
endmodule
